// ---- verilog/pcd_clock_ctrl.sv ----
`timescale 1ns/1ps
// Behaviour
// - Control pins decode as low, high, open
// - Reference select: crystal, differential, CMOS
// - Crystal oscillator off unless selected
// - Bypass low: all banks from oscillator
// - Bypass high: reference to outputs, oscillator off
// - Bypass open: bank C from reference
// - Reference divider: low 1, high 5
// - Feedback divider: low 25, high 20
// - Bank dividers: low 4, high 5, open 2
// - Compare divided reference with divided oscillator
// - Oscillator equals input times F over M
// - Bank A low outputs format select
// - Bank A high outputs format select
// - Bank B outputs format select
// - Bank C output format select
// - Power-on reset synchronises all dividers
// - Any control pin change resets dividers
// - Outputs within a bank phase aligned
module pcd_clock_ctrl (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Strap comparator senses and reference inputs
   input  wire pcd_pkg::pcd_pins_t strap,
   input  wire logic               crystal_in,
   input  wire logic               diff_ref_in,
   input  wire logic               cmos_ref_in,
   // Loop controls
   output logic                    crystal_osc_enable,
   output logic                    vco_enable,
   output logic                    pfd_ref_tick,
   output logic                    pfd_fb_tick,
   output logic                    div_reset,
   // Clock outputs and formats
   output logic      [4:0]         bank_a_outputs,
   output logic      [2:0]         bank_b_outputs,
   output logic                    bank_c_output,
   output pcd_pkg::pcd_fmt_t       out_format
);

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   localparam int NS = pcd_pkg::PCD_NUM_SYNC;
   localparam int NP = pcd_pkg::PCD_NUM_PINS;

   logic [NS-1:0] sync_in;
   logic [NS-1:0] sync1_r;
   logic [NS-1:0] sync2_r;
   logic [NS-1:0] sync3_r;
   logic [NS-1:0] stable_r;

   assign sync_in = {cmos_ref_in, diff_ref_in, crystal_in,
                     strap.hi, strap.lo};

   // Three stages; a change counts once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_r[gi]  <= 1'b0;
               sync2_r[gi]  <= 1'b0;
               sync3_r[gi]  <= 1'b0;
               stable_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= sync_in[gi];
               sync2_r[gi] <= sync1_r[gi];
               sync3_r[gi] <= sync2_r[gi];
               if (sync2_r[gi] == sync3_r[gi]) begin
                  stable_r[gi] <= sync3_r[gi];
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Three-level decode
   // ------------------------------------------------------------------
   function automatic logic [1:0] lvl_decode(input logic lo,
                                             input logic hi);
      logic [1:0] code;
      code = pcd_pkg::PCD_LVL_OPEN;
      if (lo && !hi) begin
         code = pcd_pkg::PCD_LVL_LOW;
      end else if (hi && !lo) begin
         code = pcd_pkg::PCD_LVL_HIGH;
      end
      return code;
   endfunction

   logic [2*NP-1:0] cfg_dec;

   // Each pin becomes a two-bit code; both or neither sense reads open
   generate
      for (gi = 0; gi < NP; gi++) begin : g_dec
         assign cfg_dec[2*gi +: 2] = lvl_decode(stable_r[gi],
                                                stable_r[NP+gi]);
      end
   endgenerate

   pcd_pkg::pcd_cfg_t cfg_r;
   pcd_pkg::pcd_cfg_t cfg_prev_r;
   logic              cfg_change;

   // Registered settings and their previous value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r      <= pcd_pkg::PCD_CFG_RESET;
         cfg_prev_r <= pcd_pkg::PCD_CFG_RESET;
      end else begin
         cfg_r      <= pcd_pkg::pcd_cfg_t'(cfg_dec);
         cfg_prev_r <= cfg_r;
      end
   end

   assign cfg_change = (cfg_r != cfg_prev_r);

   // ------------------------------------------------------------------
   // Ratios and configuration checks
   // ------------------------------------------------------------------
   logic [4:0] m_ratio;
   logic [4:0] f_ratio;
   logic [4:0] bank_ratio [3];
   logic       cfg_invalid;
   logic       crystal_m_conflict;

   function automatic logic [4:0] bank_decode(input logic [1:0] code);
      logic [4:0] r;
      r = pcd_pkg::PCD_BANK_OPEN;
      if (code == pcd_pkg::PCD_LVL_LOW) begin
         r = pcd_pkg::PCD_BANK_LOW;
      end else if (code == pcd_pkg::PCD_LVL_HIGH) begin
         r = pcd_pkg::PCD_BANK_HIGH;
      end
      return r;
   endfunction

   // Divider ratios from the registered settings
   assign m_ratio = (cfg_r.m_sel == pcd_pkg::PCD_LVL_HIGH) ?
                    pcd_pkg::PCD_M_HIGH : pcd_pkg::PCD_M_LOW;
   assign f_ratio = (cfg_r.f_sel == pcd_pkg::PCD_LVL_HIGH) ?
                    pcd_pkg::PCD_F_HIGH : pcd_pkg::PCD_F_LOW;
   assign bank_ratio[0] = bank_decode(cfg_r.div_a);
   assign bank_ratio[1] = bank_decode(cfg_r.div_b);
   assign bank_ratio[2] = bank_decode(cfg_r.div_c);

   // Open M or F is not a legal setting
   assign cfg_invalid = (cfg_r.m_sel == pcd_pkg::PCD_LVL_OPEN) ||
                        (cfg_r.f_sel == pcd_pkg::PCD_LVL_OPEN);
   // Board must keep M at one with the crystal chosen
   assign crystal_m_conflict = (cfg_r.ref_sel == pcd_pkg::PCD_LVL_LOW) &&
                               (cfg_r.m_sel != pcd_pkg::PCD_LVL_LOW);

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   logic        access;
   logic        wr_ctrl;
   logic        hit;
   logic [31:0] rd_data;
   logic        hold_r;
   logic        resync_r;
   logic [15:0] rscnt_r;
   logic        pready_r;
   logic [31:0] prdata_r;
   logic        pslverr_r;

   assign access  = psel && penable && !pready_r;
   assign wr_ctrl = access && pwrite && (paddr == pcd_pkg::PCD_REG_CTRL)
                    && pstrb[0];
   assign hit     = (paddr == pcd_pkg::PCD_REG_CTRL)   ||
                    (paddr == pcd_pkg::PCD_REG_STATUS) ||
                    (paddr == pcd_pkg::PCD_REG_RATIO)  ||
                    (paddr == pcd_pkg::PCD_REG_RSCNT);

   // Read multiplexer
   always_comb begin
      rd_data = 32'h00000000;
      case (paddr)
         pcd_pkg::PCD_REG_CTRL: begin
            rd_data[pcd_pkg::PCD_CTRL_HOLD_BIT] = hold_r;
         end
         pcd_pkg::PCD_REG_STATUS: begin
            rd_data[21:0] = cfg_r;
            rd_data[pcd_pkg::PCD_STAT_INVALID_BIT]  = cfg_invalid;
            rd_data[pcd_pkg::PCD_STAT_CONFLICT_BIT] = crystal_m_conflict;
            rd_data[pcd_pkg::PCD_STAT_DIVRST_BIT]   = div_reset;
         end
         pcd_pkg::PCD_REG_RATIO: begin
            rd_data[pcd_pkg::PCD_RATIO_M_POS +: 5] = m_ratio;
            rd_data[pcd_pkg::PCD_RATIO_F_POS +: 5] = f_ratio;
            rd_data[pcd_pkg::PCD_RATIO_A_POS +: 5] = bank_ratio[0];
            rd_data[pcd_pkg::PCD_RATIO_B_POS +: 5] = bank_ratio[1];
            rd_data[pcd_pkg::PCD_RATIO_C_POS +: 5] = bank_ratio[2];
         end
         pcd_pkg::PCD_REG_RSCNT: begin
            rd_data[15:0] = rscnt_r;
         end
         default: begin
            rd_data = 32'h00000000;
         end
      endcase
   end

   // Bus answer: one wait state, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= access;
         pslverr_r <= access && !hit;
         prdata_r  <= (access && !pwrite) ? rd_data : 32'h00000000;
      end
   end

   // Control register: hold level and self-clearing resync
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_r   <= pcd_pkg::PCD_HOLD_RESET;
         resync_r <= 1'b0;
      end else begin
         resync_r <= wr_ctrl && pwdata[pcd_pkg::PCD_CTRL_RESYNC_BIT];
         if (wr_ctrl) begin
            hold_r <= pwdata[pcd_pkg::PCD_CTRL_HOLD_BIT];
         end
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;

   // ------------------------------------------------------------------
   // Divider reset
   // ------------------------------------------------------------------
   logic [4:0] por_cnt_r;
   logic       por_active;
   logic       div_reset_r;

   assign por_active = (por_cnt_r != pcd_pkg::PCD_POR_LAST);

   // Power-on pulse counter after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt_r <= 5'h00;
      end else if (por_active) begin
         por_cnt_r <= por_cnt_r + 5'h01;
      end
   end

   // Reset pulse for every divider; setting changes and resyncs counted for software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reset_r <= 1'b1;
         rscnt_r     <= 16'h0000;
      end else begin
         div_reset_r <= por_active || cfg_change || resync_r ||
                        hold_r;
         if (cfg_change || resync_r) begin
            rscnt_r <= rscnt_r + 16'h0001;
         end
      end
   end

   assign div_reset = div_reset_r;

   // ------------------------------------------------------------------
   // Reference path and loop dividers
   // ------------------------------------------------------------------
   logic       ref_lvl;
   logic       ref_prev_r;
   logic       ref_rise;
   logic       bypass_all;
   logic       bypass_c;
   logic       vco_on;
   logic [4:0] m_cnt_r;
   logic [4:0] f_cnt_r;
   logic       pfd_ref_r;
   logic       pfd_fb_r;

   // Reference select on the settled input levels
   always_comb begin
      case (cfg_r.ref_sel)
         pcd_pkg::PCD_LVL_LOW:  ref_lvl = stable_r[2*NP +
                                          pcd_pkg::PCD_REF_XTAL];
         pcd_pkg::PCD_LVL_HIGH: ref_lvl = stable_r[2*NP +
                                          pcd_pkg::PCD_REF_DIFF];
         default:               ref_lvl = stable_r[2*NP +
                                          pcd_pkg::PCD_REF_CMOS];
      endcase
   end

   assign ref_rise   = ref_lvl && !ref_prev_r;
   assign bypass_all = (cfg_r.bypass == pcd_pkg::PCD_LVL_HIGH);
   assign bypass_c   = (cfg_r.bypass != pcd_pkg::PCD_LVL_LOW);
   assign vco_on     = !bypass_all;

   // Reference divider M and feedback divider F phase ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_prev_r <= 1'b0;
         m_cnt_r    <= 5'h00;
         f_cnt_r    <= 5'h00;
         pfd_ref_r  <= 1'b0;
         pfd_fb_r   <= 1'b0;
      end else begin
         ref_prev_r <= ref_lvl;
         if (div_reset_r || cfg_invalid || !vco_on) begin
            m_cnt_r   <= 5'h00;
            f_cnt_r   <= 5'h00;
            pfd_ref_r <= 1'b0;
            pfd_fb_r  <= 1'b0;
         end else begin
            pfd_ref_r <= 1'b0;
            if (ref_rise) begin
               if (m_cnt_r == m_ratio - 5'h01) begin
                  m_cnt_r   <= 5'h00;
                  pfd_ref_r <= 1'b1;
               end else begin
                  m_cnt_r <= m_cnt_r + 5'h01;
               end
            end
            if (f_cnt_r == f_ratio - 5'h01) begin
               f_cnt_r  <= 5'h00;
               pfd_fb_r <= 1'b1;
            end else begin
               f_cnt_r  <= f_cnt_r + 5'h01;
               pfd_fb_r <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Bank output dividers
   // ------------------------------------------------------------------
   logic [4:0] bank_cnt_r [3];
   logic       bank_vco   [3];

   // One counter per bank, fed from the oscillator clock
   generate
      for (gi = 0; gi < 3; gi++) begin : g_bank
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               bank_cnt_r[gi] <= 5'h00;
            end else if (div_reset_r ||
                         bank_cnt_r[gi] >= bank_ratio[gi] - 5'h01) begin
               bank_cnt_r[gi] <= 5'h00;
            end else begin
               bank_cnt_r[gi] <= bank_cnt_r[gi] + 5'h01;
            end
         end
         assign bank_vco[gi] = bank_cnt_r[gi] <
                               ((bank_ratio[gi] + 5'h01) >> 1);
      end
   endgenerate

   // Output stage: one source per bank keeps the bank aligned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_a_outputs <= 5'h00;
         bank_b_outputs <= 3'h0;
         bank_c_output  <= 1'b0;
         crystal_osc_enable <= 1'b0;
         vco_enable     <= 1'b0;
         pfd_ref_tick   <= 1'b0;
         pfd_fb_tick    <= 1'b0;
      end else begin
         bank_a_outputs <= {5{bypass_all ? ref_lvl : bank_vco[0]}};
         bank_b_outputs <= {3{bypass_all ? ref_lvl : bank_vco[1]}};
         bank_c_output  <= bypass_c ? ref_lvl : bank_vco[2];
         crystal_osc_enable <= (cfg_r.ref_sel ==
                                pcd_pkg::PCD_LVL_LOW);
         vco_enable     <= vco_on;
         pfd_ref_tick   <= pfd_ref_r;
         pfd_fb_tick    <= pfd_fb_r;
      end
   end

   // Output formats: open means disabled, high means LVPECL
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_format <= 8'h00;
      end else begin
         out_format.oe[0]   <= cfg_r.fmt_a_lo != pcd_pkg::PCD_LVL_OPEN;
         out_format.pecl[0] <= cfg_r.fmt_a_lo == pcd_pkg::PCD_LVL_HIGH;
         out_format.oe[1]   <= cfg_r.fmt_a_hi != pcd_pkg::PCD_LVL_OPEN;
         out_format.pecl[1] <= cfg_r.fmt_a_hi == pcd_pkg::PCD_LVL_HIGH;
         out_format.oe[2]   <= cfg_r.fmt_b != pcd_pkg::PCD_LVL_OPEN;
         out_format.pecl[2] <= cfg_r.fmt_b == pcd_pkg::PCD_LVL_HIGH;
         out_format.oe[3]   <= cfg_r.fmt_c != pcd_pkg::PCD_LVL_OPEN;
         out_format.pecl[3] <= cfg_r.fmt_c == pcd_pkg::PCD_LVL_HIGH;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   a_change_reset: assert property (@(posedge pclk)
      disable iff (!presetn) cfg_change |=> div_reset_r)
      else $error("setting change without divider reset");

   a_por_reset: assert property (@(posedge pclk)
      disable iff (!presetn) por_active |=> div_reset)
      else $error("power-on divider reset missing");

   a_crystal_off: assert property (@(posedge pclk)
      disable iff (!presetn) (cfg_r.ref_sel != pcd_pkg::PCD_LVL_LOW)
      |=> !crystal_osc_enable)
      else $error("crystal oscillator on while unselected");

   a_vco_bypass: assert property (@(posedge pclk)
      disable iff (!presetn)
      bypass_all |=> (!vco_enable && bank_a_outputs[0] == $past(ref_lvl)
                      && bank_c_output == $past(ref_lvl)))
      else $error("bypass did not route reference");

   a_daisy_c: assert property (@(posedge pclk)
      disable iff (!presetn) (cfg_r.bypass == pcd_pkg::PCD_LVL_OPEN) |=>
         (vco_enable && bank_c_output == $past(ref_lvl)))
      else $error("bank C not daisy chained");

   a_fb_spacing: assert property (@(posedge pclk)
      disable iff (!presetn) pfd_fb_r |=> !pfd_fb_r [*8])
      else $error("feedback ticks too close");

   a_bank_align: assert property (@(posedge pclk)
      disable iff (!presetn) $rose(bank_a_outputs[0]) |-> (&bank_a_outputs))
      else $error("bank A outputs not aligned");

   a_fmt_hiz: assert property (@(posedge pclk)
      disable iff (!presetn) (cfg_r.fmt_b == pcd_pkg::PCD_LVL_OPEN) ##1
      (cfg_r.fmt_b == pcd_pkg::PCD_LVL_OPEN) |-> !out_format.oe[2])
      else $error("bank B enabled while open");

   a_bank_div4: assert property (@(posedge pclk)
      disable iff (!presetn)
      (!div_reset_r && bank_ratio[0] == pcd_pkg::PCD_BANK_LOW &&
       bank_cnt_r[0] == 5'h03) |=> bank_cnt_r[0] == 5'h00)
      else $error("bank A divide by four wrong");

endmodule // pcd_clock_ctrl

// ---- verilog/pcd_pkg.sv ----
package pcd_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int PCD_CLK_PERIOD_NS = 20;
   localparam int PCD_POR_PULSE_NS  = 320;
   localparam int PCD_POR_CYCLES    =
      (PCD_POR_PULSE_NS + PCD_CLK_PERIOD_NS - 1) / PCD_CLK_PERIOD_NS;
   localparam logic [4:0] PCD_POR_LAST = 5'(PCD_POR_CYCLES - 1);

   // ------------------------------------------------------------------
   // Three-level pin codes
   // ------------------------------------------------------------------
   localparam logic [1:0] PCD_LVL_LOW  = 2'h0;
   localparam logic [1:0] PCD_LVL_HIGH = 2'h1;
   localparam logic [1:0] PCD_LVL_OPEN = 2'h2;

   // ------------------------------------------------------------------
   // Divider ratios
   // ------------------------------------------------------------------
   localparam logic [4:0] PCD_M_LOW     = 5'h01;
   localparam logic [4:0] PCD_M_HIGH    = 5'h05;
   localparam logic [4:0] PCD_F_LOW     = 5'h19;
   localparam logic [4:0] PCD_F_HIGH    = 5'h14;
   localparam logic [4:0] PCD_BANK_LOW  = 5'h04;
   localparam logic [4:0] PCD_BANK_HIGH = 5'h05;
   localparam logic [4:0] PCD_BANK_OPEN = 5'h02;

   // ------------------------------------------------------------------
   // Strap pin indices and reference input indices
   // ------------------------------------------------------------------
   localparam int PCD_PIN_REF      = 0;
   localparam int PCD_PIN_BYPASS   = 1;
   localparam int PCD_PIN_M        = 2;
   localparam int PCD_PIN_F        = 3;
   localparam int PCD_NUM_PINS     = 11;
   localparam int PCD_REF_XTAL     = 0;
   localparam int PCD_REF_DIFF     = 1;
   localparam int PCD_REF_CMOS     = 2;
   localparam int PCD_NUM_SYNC     = 2 * PCD_NUM_PINS + 3;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [11:0] PCD_REG_CTRL   = 12'h000;
   localparam logic [11:0] PCD_REG_STATUS = 12'h004;
   localparam logic [11:0] PCD_REG_RATIO  = 12'h008;
   localparam logic [11:0] PCD_REG_RSCNT  = 12'h00C;
   localparam int PCD_CTRL_RESYNC_BIT     = 0;
   localparam int PCD_CTRL_HOLD_BIT       = 1;
   localparam logic PCD_HOLD_RESET        = 1'b0;
   localparam int PCD_STAT_INVALID_BIT    = 22;
   localparam int PCD_STAT_CONFLICT_BIT   = 23;
   localparam int PCD_STAT_DIVRST_BIT     = 24;
   localparam int PCD_RATIO_M_POS         = 0;
   localparam int PCD_RATIO_F_POS         = 8;
   localparam int PCD_RATIO_A_POS         = 16;
   localparam int PCD_RATIO_B_POS         = 21;
   localparam int PCD_RATIO_C_POS         = 26;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] fmt_c;
      logic [1:0] fmt_b;
      logic [1:0] fmt_a_hi;
      logic [1:0] fmt_a_lo;
      logic [1:0] div_c;
      logic [1:0] div_b;
      logic [1:0] div_a;
      logic [1:0] f_sel;
      logic [1:0] m_sel;
      logic [1:0] bypass;
      logic [1:0] ref_sel;
   } pcd_cfg_t;

   localparam pcd_cfg_t PCD_CFG_RESET = 22'h000000;

   typedef struct packed {
      logic [PCD_NUM_PINS-1:0] hi;
      logic [PCD_NUM_PINS-1:0] lo;
   } pcd_pins_t;

   typedef struct packed {
      logic [3:0] oe;
      logic [3:0] pecl;
   } pcd_fmt_t;

endpackage

// ---- sim/pcd_strap_model.sv ----
`timescale 1ns/1ps
module pcd_strap_model (
   // Pin levels chosen by the bench
   input  wire pcd_pkg::pcd_cfg_t  levels,
   // Comparator senses and reference lines
   output pcd_pkg::pcd_pins_t      strap,
   output logic                    crystal_in,
   output logic                    diff_ref_in,
   output logic                    cmos_ref_in
);
   logic ref_clk;
   // Free reference oscillator, unrelated in phase to pclk
   initial begin
      ref_clk = 1'b0;
      forever #17 ref_clk = ~ref_clk;
   end
   // Open pin leaves both comparator senses low
   always_comb begin
      for (int i = 0; i < pcd_pkg::PCD_NUM_PINS; i++) begin
         strap.lo[i] = (levels[2*i +: 2] == pcd_pkg::PCD_LVL_LOW);
         strap.hi[i] = (levels[2*i +: 2] == pcd_pkg::PCD_LVL_HIGH);
      end
   end
   // Only the selected reference input carries a signal
   assign crystal_in  = (levels.ref_sel == pcd_pkg::PCD_LVL_LOW) & ref_clk;
   assign diff_ref_in = (levels.ref_sel == pcd_pkg::PCD_LVL_HIGH) & ref_clk;
   assign cmos_ref_in = (levels.ref_sel == pcd_pkg::PCD_LVL_OPEN) & ref_clk;
endmodule // pcd_strap_model

// ---- sim/pin_strapped_clock_divider_mux_bench.sv ----
`timescale 1ns/1ps
module pin_strapped_clock_divider_mux_bench;
   localparam logic [1:0] LV [3] = '{pcd_pkg::PCD_LVL_HIGH,
      pcd_pkg::PCD_LVL_OPEN, pcd_pkg::PCD_LVL_LOW};
   logic               pclk, presetn, psel, penable, pwrite, err;
   logic [11:0]        paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic               pready, pslverr, crystal_in, diff_ref_in;
   logic               cmos_ref_in, crystal_osc_enable, vco_enable;
   logic               div_reset, pfd_fb_tick, bank_c_output;
   logic [4:0]         bank_a_outputs;
   logic [2:0]         bank_b_outputs;
   pcd_pkg::pcd_pins_t strap;
   pcd_pkg::pcd_fmt_t  out_format;
   pcd_pkg::pcd_cfg_t  cfg;
   int                 fails, checked;

   // Strap board and reference sources
   pcd_strap_model strap_board (.levels(cfg), .strap(strap),
      .crystal_in(crystal_in), .diff_ref_in(diff_ref_in),
      .cmos_ref_in(cmos_ref_in));
   pcd_clock_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .strap(strap), .crystal_in(crystal_in), .diff_ref_in(diff_ref_in),
      .cmos_ref_in(cmos_ref_in), .crystal_osc_enable(crystal_osc_enable),
      .vco_enable(vco_enable), .pfd_ref_tick(), .pfd_fb_tick(pfd_fb_tick),
      .div_reset(div_reset), .bank_a_outputs(bank_a_outputs),
      .bank_b_outputs(bank_b_outputs), .bank_c_output(bank_c_output),
      .out_format(out_format));

   task automatic chk(input string nm, input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // APB transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd = 32'h00000000);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Move one strap pin and watch the divider reset and bank alignment
   task automatic set_pin(input int p, input logic [1:0] lvl);
      logic seen, algn, moved;
      seen = 1'b0;
      algn = 1'b1;
      moved = (cfg[2*p +: 2] != lvl);
      @(posedge pclk);
      cfg[2*p +: 2] <= lvl;
      repeat (10) begin
         @(negedge pclk);
         seen |= div_reset;
         algn &= (bank_a_outputs === {5{bank_a_outputs[0]}}) &&
                 (bank_b_outputs === {3{bank_b_outputs[0]}});
      end
      if (moved) chk("div_reset pulse", seen, 1);
      chk("div_reset idle", div_reset, 0);
      chk("bank alignment", algn, 1);
   endtask
   task automatic t_ref_bypass();
      foreach (LV[i]) begin
         set_pin(pcd_pkg::PCD_PIN_REF, LV[i]);
         chk("crystal_osc_enable", crystal_osc_enable,
             LV[i] == pcd_pkg::PCD_LVL_LOW);
         apb(1'b0, pcd_pkg::PCD_REG_STATUS);
         chk("ref code", rd[1:0], LV[i]);
         set_pin(pcd_pkg::PCD_PIN_BYPASS, LV[i]);
         chk("vco_enable", vco_enable, LV[i] != pcd_pkg::PCD_LVL_HIGH);
      end
   endtask
   // Reference stays differential while M is high
   task automatic t_ratio(input logic [1:0] m, f, a, b, c,
                          input logic [4:0] em, ef, ea, eb, ec);
      int n;
      set_pin(pcd_pkg::PCD_PIN_REF, pcd_pkg::PCD_LVL_HIGH);
      set_pin(pcd_pkg::PCD_PIN_M, m);
      set_pin(pcd_pkg::PCD_PIN_F, f);
      for (int p = 4; p < 7; p++) set_pin(p, p == 4 ? a : p == 5 ? b : c);
      apb(1'b0, pcd_pkg::PCD_REG_RATIO);
      chk("ratio M", rd[4:0], em);
      chk("ratio F", rd[12:8], ef);
      chk("ratio banks", rd[30:16], {ec, eb, ea});
      // Feedback ticks come once every F cycles
      n = 0;
      @(posedge pfd_fb_tick);
      @(negedge pclk);
      do begin
         @(negedge pclk);
         n++;
      end while (pfd_fb_tick !== 1'b1);
      chk("fb tick gap", n, ef);
   endtask
   task automatic t_format_regs();
      for (int p = 7; p < 11; p++) foreach (LV[i]) begin
         set_pin(p, LV[i]);
         chk("oe", out_format.oe[p-7], LV[i] != pcd_pkg::PCD_LVL_OPEN);
         chk("pecl", out_format.pecl[p-7], LV[i] == pcd_pkg::PCD_LVL_HIGH);
      end
      set_pin(pcd_pkg::PCD_PIN_F, pcd_pkg::PCD_LVL_OPEN);
      apb(1'b0, pcd_pkg::PCD_REG_STATUS);
      chk("invalid flag", rd[22], 1);
      apb(1'b0, 12'h010);
      chk("unmapped err", err, 1'b1);
      chk("unmapped data", rd, 32'h00000000);
   endtask
   // Software hold and resync drive the divider reset
   task automatic t_ctrl();
      logic [31:0] cnt;
      apb(1'b1, pcd_pkg::PCD_REG_CTRL, 32'h00000002);
      repeat (3) @(negedge pclk);
      chk("hold reset", div_reset, 1'b1);
      apb(1'b0, pcd_pkg::PCD_REG_CTRL);
      chk("hold readback", rd, 32'h00000002);
      apb(1'b0, pcd_pkg::PCD_REG_RSCNT);
      cnt = rd;
      apb(1'b1, pcd_pkg::PCD_REG_CTRL, 32'h00000001);
      @(negedge pclk);
      chk("resync pulse", div_reset, 1'b1);
      @(negedge pclk);
      chk("resync end", div_reset, 1'b0);
      apb(1'b0, pcd_pkg::PCD_REG_RSCNT);
      chk("reset count", rd, cnt + 32'h00000001);
   endtask
   task automatic end_of_test();
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Clock and watchdog
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      repeat (6000) @(posedge pclk);
      fails++;
      end_of_test();
   end
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      cfg = '0;
      fails = 0;
      checked = 0;
      repeat (2) @(posedge pclk);
      chk("div_reset in reset", div_reset, 1);
      presetn <= 1'b1;
      repeat (5) @(negedge pclk);
      chk("power-on pulse", div_reset, 1);
      repeat (30) @(negedge pclk);
      chk("power-on end", div_reset, 0);
      t_ref_bypass();
      t_ratio(LV[0], LV[0], LV[2], LV[0], LV[1], pcd_pkg::PCD_M_HIGH,
         pcd_pkg::PCD_F_HIGH, pcd_pkg::PCD_BANK_LOW, pcd_pkg::PCD_BANK_HIGH,
         pcd_pkg::PCD_BANK_OPEN);
      t_ratio(LV[2], LV[2], LV[1], LV[2], LV[0], pcd_pkg::PCD_M_LOW,
         pcd_pkg::PCD_F_LOW, pcd_pkg::PCD_BANK_OPEN, pcd_pkg::PCD_BANK_LOW,
         pcd_pkg::PCD_BANK_HIGH);
      t_ctrl();
      t_format_regs();
      end_of_test();
   end
endmodule // pin_strapped_clock_divider_mux_bench
